// ### src/seb_regs.svh
`ifndef SEB_REGS_SVH
`define SEB_REGS_SVH
// Purpose: Constants of the serial EEPROM bus slave.
// Assumes: A 25 ns system clock.
// Notes:   Times are kept in their own unit and converted to cycles here.

`define SEB_CLK_NS      25
`define SEB_HOLD_NS     300
`define SEB_HOLD_CYC    ((`SEB_HOLD_NS + `SEB_CLK_NS - 1) / `SEB_CLK_NS)
`define SEB_PROG_MS     10
`define SEB_PROG_CYC    ((`SEB_PROG_MS * 1000000) / `SEB_CLK_NS)
`define SEB_CODE_MEM    4'hA
`define SEB_CODE_PROT   4'h6
`define SEB_SWP_LIMIT   8'h80
`define SEB_BLANK       8'hFF
`define SEB_LAST_SLOT   4'hF
`define SEB_BYTE_DONE   4'h8
`define SEB_LAST_BIT    4'h7
`define SEB_FIFO_DEPTH  32

`endif

// ### src/seb_pkg.sv
// Purpose: Types shared by the serial EEPROM bus slave.
// Assumes: Nothing beyond the constants header.
// Notes:   State codes are one-hot.
package seb_pkg;

   typedef enum logic [5:0]
   {
      SEB_IDLE = 6'h01,
      SEB_RECV = 6'h02,
      SEB_ACK  = 6'h04,
      SEB_SEND = 6'h08,
      SEB_MACK = 6'h10,
      SEB_WAIT = 6'h20
   } seb_state_e;

   typedef enum logic [3:0]
   {
      ROLE_CTRL = 4'h1,
      ROLE_ADDR = 4'h2,
      ROLE_DATA = 4'h4,
      ROLE_PROT = 4'h8
   } seb_role_e;

   typedef struct packed
   {
      logic       scl;
      logic       sda;
      logic       wp;
      logic [2:0] cs;
   } seb_pins_s;

   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] data;
   } seb_wr_s;

endpackage : seb_pkg

// ### src/seb_sync.sv
// Purpose: Two-stage synchroniser for the slave's pin inputs.
// Assumes: Pins are asynchronous to clk.
// Notes:   Only the second stage is visible outside.
module seb_sync
(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               srst,
   // Pins
   input  wire seb_pkg::seb_pins_s raw,
   output      seb_pkg::seb_pins_s synced
);
   import seb_pkg::*;

   typedef struct packed
   {
      seb_pins_s s1;
      seb_pins_s s2;
   } seb_sync_s;

   seb_sync_s r;
   seb_sync_s next_r;

   always_comb
   begin
      next_r    = r;
      next_r.s1 = raw;
      next_r.s2 = r.s1;
      if (srst)
      begin
         // Idle bus levels, so no false START is seen after reset.
         next_r     = '0;
         next_r.s1.scl = 1'b1;
         next_r.s1.sda = 1'b1;
         next_r.s2.scl = 1'b1;
         next_r.s2.sda = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      r <= next_r;
   end

   assign synced = r.s2;

endmodule : seb_sync

// ### src/seb_fifo.sv
// Purpose: Write-commit FIFO between the page buffer and the array.
// Assumes: Single clock, synchronous reset.
// Notes:   Pointers carry one extra bit to tell full from empty.
`include "seb_regs.svh"
module seb_fifo
#(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = `SEB_FIFO_DEPTH
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             srst,
   // Fill side
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   import seb_pkg::*;

   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wr;
      logic [AW:0]                 rd;
   } seb_fifo_s;

   seb_fifo_s r;
   seb_fifo_s next_r;
   logic      full;
   logic      empty;

   always_comb
   begin
      next_r = r;
      empty  = (r.wr == r.rd);
      full   = (r.wr[AW] != r.rd[AW]) && (r.wr[AW-1:0] == r.rd[AW-1:0]);
      if (in_valid && !full)
      begin
         next_r.mem[r.wr[AW-1:0]] = in_data;
         next_r.wr                = r.wr + 1'b1;
      end
      if (out_ready && !empty)
      begin
         next_r.rd = r.rd + 1'b1;
      end
      if (srst)
      begin
         next_r = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      r <= next_r;
   end

   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = r.mem[r.rd[AW-1:0]];

endmodule : seb_fifo

// ### src/seb_top.sv
// Purpose: Two-wire bus slave of a 256 x 8 serial EEPROM.
// Assumes: Bus pins are asynchronous and pass two flip-flops first.
// Notes:   SDA is open drain; the enable is low while pulling low.
//
// What the master and this block do
// [RL1] SDA falling while SCL high is START and opens a transaction.
// [RL2] SDA rising while SCL high is STOP and ends the transaction.
// [RL3] Master opens each command with START, closes each with STOP.
// [RL4] Transmitter changes SDA only while SCL low, one clock per bit.
// [RL5] Master starts only on an idle bus, both lines high.
// [RL6] Unlimited write bytes accepted; only the last sixteen are kept.
// [RL7] Receiver acknowledges each byte on a ninth clock from the master.
// [RL8] No acknowledge at all while a programming cycle runs.
// [RL9] Acknowledge holds SDA low through the whole ninth clock high.
// [RL10] Master withholds ack on last read byte; device releases SDA.
// [RL11] Control code 1010 selects memory, 0110 the protect register.
// [RL12] Respond only when the chip-select bits equal the select pins.
// [RL13] Last control bit one means read, zero means write.
// [RL14] Protect code with read direction is not acknowledged.
// [RL15] Software protection blocks programming of the lower 128 bytes.
// [RL16] Software protection is set by command and cleared only by reset.
// [RL17] Protect pin high blocks programming of the whole array.
// [RL18] Array of 256 bytes addressed by one eight-bit word address.
// [RL19] Page buffer of 16 bytes programmed in one write cycle.
// [RL20] Self-timed program cycle with erase, at most 10 ms.
// [RL21] Output held at least 300 ns after SCL falls.
// [RL22] Page writes bump only the low four pointer bits.
// [RL23] Protected writes are acknowledged, store nothing, still take time.
// [RL24] Once protection is set, the protect code is not acknowledged.
// [RL25] Pointer increments after each byte read for sequential reads.
// [RL26] Byte after a write control byte loads the address pointer.
`include "seb_regs.svh"
module seb_top
#(
   parameter int unsigned PROG_CYCLES = `SEB_PROG_CYC
)
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Two-wire bus
   input  wire logic scl_pin,
   input  wire logic sda_in,
   output      logic sda_out,
   output      logic sda_oe_n,
   // Straps
   input  wire logic chip_select_pin_0,
   input  wire logic chip_select_pin_1,
   input  wire logic chip_select_pin_2,
   input  wire logic write_protect_pin,
   // Status
   output      logic prog_busy
);
   import seb_pkg::*;

   localparam logic [23:0] PROG_LOAD = 24'(PROG_CYCLES - 1);
   localparam logic [23:0] PROG_HALF = 24'(PROG_CYCLES / 2);
   localparam logic [3:0]  HOLD_LOAD = 4'(`SEB_HOLD_CYC);

   typedef struct packed
   {
      seb_state_e         state;
      seb_role_e          role;
      logic               scl_d;
      logic               sda_d;
      logic [3:0]         cnt;
      logic [7:0]         sh;
      logic [7:0]         tx;
      logic               go_tx;
      logic               mack;
      logic [7:0]         ptr;
      logic [15:0]        vld;
      logic [15:0][7:0]   page;
      logic               prot_pend;
      logic               swp;
      logic               want_low;
      logic               rel;
      logic [3:0]         hold;
      logic               busy;
      logic [23:0]        timer;
      logic               commit;
      logic [3:0]         slot;
      logic [255:0][7:0]  mem;
   } seb_core_s;

   seb_core_s r;
   seb_core_s next_r;
   seb_pins_s raw;
   seb_pins_s pins;
   logic      push_valid;
   logic      push_ready;
   seb_wr_s   push_word;
   logic      pop_valid;
   logic      pop_ready;
   seb_wr_s   pop_word;

   // Pin protection overrides the software bit for the whole array.
   function automatic logic is_protected(input logic [7:0] addr,
                                         input logic       wp,
                                         input logic       swp);
      is_protected = wp || (swp && (addr < `SEB_SWP_LIMIT));
   endfunction : is_protected

   assign raw.scl = scl_pin;
   assign raw.sda = sda_in;
   assign raw.wp  = write_protect_pin;
   assign raw.cs  = {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};

   seb_sync u_sync
   (
      .clk    (clk),
      .srst   (srst),
      .raw    (raw),
      .synced (pins)
   );

   seb_fifo #(.WIDTH($bits(seb_wr_s)), .DEPTH(`SEB_FIFO_DEPTH)) u_fifo
   (
      .clk       (clk),
      .srst      (srst),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_word),
      .out_valid (pop_valid),
      .out_ready (pop_ready),
      .out_data  (pop_word)
   );

   always_comb
   begin
      logic scl_rise;
      logic scl_fall;
      logic start_c;
      logic stop_c;
      logic ack;
      logic load_tx;
      logic adv;
      logic [7:0] waddr;
      scl_rise   = pins.scl && !r.scl_d;
      scl_fall   = !pins.scl && r.scl_d;
      start_c    = pins.scl && r.scl_d && r.sda_d && !pins.sda;    // [RL1]
      stop_c     = pins.scl && r.scl_d && !r.sda_d && pins.sda;    // [RL2]
      ack        = 1'b0;
      load_tx    = 1'b0;
      adv        = 1'b0;
      waddr      = {r.ptr[7:4], r.slot};
      next_r     = r;
      push_valid = 1'b0;
      push_word  = '0;
      pop_ready  = 1'b0;
      next_r.scl_d = pins.scl;
      next_r.sda_d = pins.sda;

      // Each output change waits out the hold time after SCL falls, so
      // the line never moves while SCL is still in its undefined region.
      if (scl_fall)
      begin
         next_r.hold = HOLD_LOAD;                                  // [RL21]
      end
      else if (r.hold != 4'h0)
      begin
         next_r.hold = r.hold - 4'h1;
      end
      if (r.hold == 4'h1)
      begin
         next_r.rel = !r.want_low;                                 // [RL4]
      end

      case (r.state)
         SEB_RECV:
         begin
            if (scl_rise)
            begin
               next_r.sh  = {r.sh[6:0], pins.sda};                 // [RL4]
               next_r.cnt = r.cnt + 4'h1;
            end
            else if (scl_fall && (r.cnt == `SEB_BYTE_DONE))
            begin
               next_r.cnt = 4'h0;
               case (r.role)
                  ROLE_CTRL:
                  begin
                     if (!r.busy && (r.sh[3:1] == pins.cs))   // [RL8] [RL12]
                     begin
                        if (r.sh[7:4] == `SEB_CODE_MEM)            // [RL11]
                        begin
                           ack = 1'b1;
                           if (r.sh[0])                            // [RL13]
                           begin
                              next_r.go_tx = 1'b1;
                           end
                           else
                           begin
                              next_r.role = ROLE_ADDR;
                           end
                        end
                        else if ((r.sh[7:4] == `SEB_CODE_PROT) &&
                                 !r.sh[0] && !r.swp)   // [RL14] [RL24]
                        begin
                           ack         = 1'b1;
                           next_r.role = ROLE_PROT;
                        end
                     end
                  end
                  ROLE_ADDR:
                  begin
                     ack         = 1'b1;
                     next_r.ptr  = r.sh;                   // [RL18] [RL26]
                     next_r.vld  = 16'h0000;
                     next_r.role = ROLE_DATA;
                  end
                  ROLE_DATA:
                  begin
                     // Wrapping overwrites the oldest slot of the page.
                     ack                      = 1'b1;
                     next_r.page[r.ptr[3:0]]  = r.sh;      // [RL6] [RL19]
                     next_r.vld[r.ptr[3:0]]   = 1'b1;
                     next_r.ptr = {r.ptr[7:4], r.ptr[3:0] + 4'h1}; // [RL22]
                  end
                  ROLE_PROT:
                  begin
                     ack              = 1'b1;
                     next_r.prot_pend = 1'b1;
                  end
                  default:
                  begin
                     ack = 1'b0;
                  end
               endcase
               next_r.want_low = ack;                              // [RL7]
               next_r.state    = ack ? SEB_ACK : SEB_WAIT;
            end
         end
         SEB_ACK:
         begin
            // Pull stays on until the ninth clock has fallen.
            if (scl_fall)                                          // [RL9]
            begin
               if (r.go_tx)
               begin
                  load_tx = 1'b1;
               end
               else
               begin
                  next_r.want_low = 1'b0;
                  next_r.state    = SEB_RECV;
               end
            end
         end
         SEB_SEND:
         begin
            if (scl_fall)
            begin
               if (r.cnt == `SEB_LAST_BIT)
               begin
                  next_r.want_low = 1'b0;
                  next_r.state    = SEB_MACK;
                  next_r.cnt      = 4'h0;
               end
               else
               begin
                  next_r.tx       = {r.tx[6:0], 1'b0};
                  next_r.want_low = !r.tx[6];                      // [RL4]
                  next_r.cnt      = r.cnt + 4'h1;
               end
            end
         end
         SEB_MACK:
         begin
            if (scl_rise)
            begin
               next_r.mack = !pins.sda;
            end
            else if (scl_fall)
            begin
               if (r.mack)
               begin
                  load_tx = 1'b1;
               end
               else
               begin
                  next_r.want_low = 1'b0;                          // [RL10]
                  next_r.state    = SEB_WAIT;
               end
            end
         end
         default:
         begin
            next_r.state = r.state;
         end
      endcase

      if (load_tx)
      begin
         next_r.tx       = r.mem[r.ptr];
         next_r.want_low = !r.mem[r.ptr][7];
         next_r.ptr      = r.ptr + 8'h01;                          // [RL25]
         next_r.cnt      = 4'h0;
         next_r.state    = SEB_SEND;
      end

      if (start_c)
      begin
         // A repeated START drops buffered bytes without programming.
         next_r.state     = SEB_RECV;                              // [RL1]
         next_r.role      = ROLE_CTRL;
         next_r.cnt       = 4'h0;
         next_r.go_tx     = 1'b0;
         next_r.prot_pend = 1'b0;
         next_r.want_low  = 1'b0;
         next_r.rel       = 1'b1;
         next_r.hold      = 4'h0;
         if (!r.busy)
         begin
            next_r.vld = 16'h0000;
         end
      end
      else if (stop_c)
      begin
         next_r.state     = SEB_IDLE;                              // [RL2]
         next_r.want_low  = 1'b0;
         next_r.rel       = 1'b1;
         next_r.hold      = 4'h0;
         next_r.go_tx     = 1'b0;
         next_r.prot_pend = 1'b0;
         if (!r.busy && (((r.role == ROLE_DATA) && (r.vld != 16'h0000)) ||
                         r.prot_pend))
         begin
            next_r.busy   = 1'b1;                                  // [RL20]
            next_r.timer  = PROG_LOAD;
            next_r.commit = (r.role == ROLE_DATA);
            next_r.slot   = 4'h0;
            if (r.prot_pend && !pins.wp)                          // [RL17]
            begin
               next_r.swp = 1'b1;                                  // [RL16]
            end
         end
      end

      // Walk the page; protected slots are skipped but time still runs.
      if (r.commit)
      begin
         if (r.vld[r.slot] && !is_protected(waddr, pins.wp, r.swp))
         begin
            push_valid     = 1'b1;                 // [RL15] [RL17] [RL23]
            push_word.addr = waddr;
            push_word.data = r.page[r.slot];
            adv            = push_ready;
         end
         else
         begin
            adv = 1'b1;
         end
         if (adv)
         begin
            next_r.slot   = r.slot + 4'h1;
            next_r.commit = (r.slot != `SEB_LAST_SLOT);
         end
      end

      // The first half models the erase; array writes land in the second.
      if (r.busy)
      begin
         if (r.timer != 24'h000000)
         begin
            next_r.timer = r.timer - 24'h000001;
         end
         pop_ready = (r.timer <= PROG_HALF);                       // [RL20]
         if (pop_valid && pop_ready)
         begin
            next_r.mem[pop_word.addr] = pop_word.data;             // [RL19]
         end
         if ((r.timer == 24'h000000) && !r.commit && !pop_valid)
         begin
            next_r.busy = 1'b0;
         end
      end

      if (srst)
      begin
         next_r       = '0;
         next_r.state = SEB_IDLE;
         next_r.role  = ROLE_CTRL;
         next_r.scl_d = 1'b1;
         next_r.sda_d = 1'b1;
         next_r.rel   = 1'b1;
         next_r.mem   = {256{`SEB_BLANK}};
      end
   end

   always_ff @(posedge clk)
   begin
      r <= next_r;
   end

   // Open drain: the driven level is always low, so both follow one flop.
   assign sda_out   = r.rel;
   assign sda_oe_n  = r.rel;
   assign prog_busy = r.busy;

endmodule : seb_top

// ### tb/seb_asserts.sv
// Purpose: Timing checks on the bus slave's pins and busy flag.
// Assumes: Sees only the top module's ports.
// Notes:   Counters give the long waits a firm figure.
module seb_asserts
#(
   parameter int unsigned PROG_CYCLES = 400000
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Bus and straps
   input wire logic scl_pin,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic chip_select_pin_0,
   input wire logic chip_select_pin_1,
   input wire logic chip_select_pin_2,
   input wire logic write_protect_pin,
   input wire logic prog_busy
);
   localparam logic [19:0] PROG_N = 20'(PROG_CYCLES);
   logic [5:0]  low_cnt;
   logic [5:0]  stop_age;
   logic [19:0] busy_cnt;
   logic        sda_q;

   always_ff @(posedge clk)
   begin
      sda_q    <= sda_in;
      low_cnt  <= scl_pin ? 6'h00 : low_cnt + {5'h00, low_cnt != 6'h3F};
      stop_age <= (scl_pin && sda_in && !sda_q) ? 6'h00 :
                  stop_age + {5'h00, stop_age != 6'h3F};
      busy_cnt <= prog_busy ? busy_cnt + 20'h00001 : 20'h00000;
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (srst);

   sequence drv_start;
      $fell(sda_oe_n);
   endsequence
   sequence drv_hold;
      !sda_oe_n [*8];
   endsequence
   // The sync pipeline adds a few cycles on top of the 12-cycle hold.
   sequence held_low;
      low_cnt >= 6'h0C && low_cnt <= 6'h14;
   endsequence

   reset_idle_a: assert property ($fell(srst) |-> sda_oe_n && !prog_busy)
      else $error("bus driven or busy after reset");
   out_level_a: assert property (sda_out == sda_oe_n)
      else $error("sda_out differs from enable");
   busy_len_a: assert property
      ($fell(prog_busy) |-> busy_cnt == PROG_N)
      else $error("program cycle length wrong");
   busy_cap_a: assert property (busy_cnt <= PROG_N)
      else $error("program cycle overran");
   busy_quiet_a: assert property (prog_busy |-> sda_oe_n)
      else $error("bus driven while programming");
   busy_after_stop_a: assert property
      ($rose(prog_busy) |-> stop_age <= 6'h08)
      else $error("program cycle without stop");
   drive_delay_a: assert property (drv_start |-> held_low)
      else $error("drive began off the hold delay");
   release_delay_a: assert property
      ($rose(sda_oe_n) && !scl_pin |-> held_low)
      else $error("release off the hold delay");
   drive_scl_low_a: assert property (drv_start |-> !scl_pin)
      else $error("drive began with clock high");
   ack_hold_a: assert property
      ($rose(scl_pin) && !sda_oe_n |-> drv_hold)
      else $error("low level not held through clock high");
endmodule : seb_asserts

bind seb_top seb_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk
(
   .clk               (clk),
   .srst              (srst),
   .scl_pin           (scl_pin),
   .sda_in            (sda_in),
   .sda_out           (sda_out),
   .sda_oe_n          (sda_oe_n),
   .chip_select_pin_0 (chip_select_pin_0),
   .chip_select_pin_1 (chip_select_pin_1),
   .chip_select_pin_2 (chip_select_pin_2),
   .write_protect_pin (write_protect_pin),
   .prog_busy         (prog_busy)
);

// ### tb/seb_master.sv
// Purpose: Behavioural two-wire bus master driving the slave.
// Assumes: 40 clk a bit, clock low 24 and high 16 cycles.
// Notes:   A released data line reads as the pull-up level.
module seb_master
(
   // Clock
   input  wire logic clk,
   // Bus
   output      logic scl,
   output      logic sda_low,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tk

   // Data moves only while the clock is low, one pulse a bit.
   task automatic bit_io(input logic b, output logic v);
      tk(4);
      sda_low = !b;
      tk(20);
      scl = 1'b1;
      tk(8);
      v = sda;
      tk(8);
      scl = 1'b0;
   endtask : bit_io

   task automatic cond(input logic first, input logic last);
      tk(4);
      sda_low = first;
      tk(20);
      scl = 1'b1;
      tk(16);
      sda_low = last;
      tk(16);
   endtask : cond

   task automatic start();
      cond(1'b0, 1'b1);
      scl = 1'b0;
   endtask : start

   task automatic stop();
      cond(1'b1, 1'b0);
   endtask : stop

   task automatic send(input logic [7:0] b, output logic ack);
      logic v;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], v);
      bit_io(1'b1, v);
      ack = !v;
   endtask : send

   task automatic recv(input logic more, output logic [7:0] d);
      logic v;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(!more, v);
   endtask : recv
endmodule : seb_master

// ### tb/tb_top.sv
// Purpose: Self-checking bench of the serial EEPROM bus slave.
// Assumes: Program cycle shortened through PROG_CYCLES.
// Notes:   Bus clock is slower than the link rate so the hold fits.
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("mismatch t=%0t got %h exp %h", $time, got, exp); \
      end \
   end

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int unsigned PROG_N = 2000;
   logic       clk  = 1'b0;
   logic       srst = 1'b1;
   logic       wp   = 1'b0;
   logic [2:0] cs;
   wire        scl;
   wire        m_low;
   wire        sda_oe_n;
   wire        prog_busy;
   wire        sda = !(m_low || !sda_oe_n);
   int         seed = 32'h61A6;
   int         err_total = 0;
   int         num_checks = 0;
   int         cyc = 0;
   logic [7:0] mem [256];
   logic [7:0] pend [16];
   bit         pv [16];
   bit         swp;
   logic       ack;
   logic [7:0] d;
   logic [7:0] ptr;
   logic [7:0] bad [4];

   seb_master m
   (
      .clk     (clk),
      .scl     (scl),
      .sda_low (m_low),
      .sda     (sda)
   );

   seb_top #(.PROG_CYCLES(PROG_N)) uut
   (
      .clk               (clk),
      .srst              (srst),
      .scl_pin           (scl),
      .sda_in            (sda),
      .sda_out           (),
      .sda_oe_n          (sda_oe_n),
      .chip_select_pin_0 (cs[0]),
      .chip_select_pin_1 (cs[1]),
      .chip_select_pin_2 (cs[2]),
      .write_protect_pin (wp),
      .prog_busy         (prog_busy)
   );

   always #12.5 clk = !clk;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         err_total++;
         report_and_stop();
      end
   end

   function automatic logic [7:0] ctl(input logic [3:0] code, input logic rd);
      return {code, cs, rd};
   endfunction : ctl

   // Sends n random bytes; the model commits only unprotected slots.
   task automatic wr(input logic [7:0] c, input logic [7:0] a, input int n,
                     input logic exp);
      logic [7:0] p;
      p  = a;
      pv = '{default: 1'b0};
      m.start();
      m.send(c, ack);
      `CHK(ack, exp)
      if (ack === 1'b1)
      begin
         m.send(a, ack);
         repeat (n)
         begin
            d = 8'($random(seed));
            m.send(d, ack);
            `CHK(ack, 1'b1)
            pend[p[3:0]] = d;
            pv[p[3:0]]   = 1'b1;
            p[3:0]       = p[3:0] + 4'h1;
         end
      end
      m.stop();
      `CHK(prog_busy, exp)
      if (exp && c[7:4] == 4'h6)
         swp = swp || !wp;
      for (int k = 0; k < 16; k++)
         if (exp && c[7:4] == 4'hA && pv[k] && !wp && !(swp && !a[7]))
            mem[{a[7:4], k[3:0]}] = pend[k];
      if (exp)
      begin
         m.start();
         m.send(ctl(4'hA, 1'b0), ack);
         `CHK(ack, 1'b0)
         m.stop();
      end
      for (int k = 0; k < 4000 && prog_busy !== 1'b0; k++)
         @(posedge clk);
      #1;
      `CHK(prog_busy, 1'b0)
   endtask : wr

   task automatic rd(input logic [7:0] a, input int n, input logic set);
      if (set)
      begin
         m.start();
         m.send(ctl(4'hA, 1'b0), ack);
         m.send(a, ack);
      end
      m.start();
      m.send(ctl(4'hA, 1'b1), ack);
      `CHK(ack, 1'b1)
      for (int k = 0; k < n; k++)
      begin
         m.recv(k < n - 1, d);
         `CHK(d, mem[a])
         a++;
      end
      m.stop();
      ptr = a;
   endtask : rd

   initial
   begin
      cs  = 3'($random(seed));
      swp = 1'b0;
      foreach (mem[i])
         mem[i] = 8'hFF;
      repeat (5) @(posedge clk);
      #1;
      srst = 1'b0;
      `CHK(sda_oe_n, 1'b1)
      `CHK(prog_busy, 1'b0)
      repeat (4) @(posedge clk);
      #1;
      rd(8'h3C, 1, 1'b1);
      // Eighteen bytes from slot C wrap the page and overwrite two.
      wr(ctl(4'hA, 1'b0), 8'h3C, 18, 1'b1);
      rd(8'h30, 20, 1'b1);
      rd(ptr, 2, 1'b0);
      bad = '{{4'hA, ~cs, 1'b0}, ctl(4'h5, 1'b0), ctl(4'h6, 1'b1),
              ctl(4'h2, 1'b0)};
      foreach (bad[i])
         wr(bad[i], 8'h00, 1, 1'b0);
      wp = 1'b1;
      wr(ctl(4'hA, 1'b0), 8'hC0, 3, 1'b1);
      wr(ctl(4'h6, 1'b0), 8'h00, 1, 1'b1);
      wp = 1'b0;
      wr(ctl(4'hA, 1'b0), 8'h20, 2, 1'b1);
      rd(8'h20, 2, 1'b1);
      wr(ctl(4'h6, 1'b0), 8'h00, 1, 1'b1);
      wr(ctl(4'h6, 1'b0), 8'h00, 1, 1'b0);
      wr(ctl(4'hA, 1'b0), 8'h7E, 2, 1'b1);
      wr(ctl(4'hA, 1'b0), 8'h80, 2, 1'b1);
      rd(8'h7E, 4, 1'b1);
      rd(8'hC0, 3, 1'b1);
      report_and_stop();
   end
endmodule : tb_top
